/* rtl/ctfw_writer.sv */
`timescale 1ns/1ns
// Operation
// RL1 - Eight data bits then double parity cell
// RL2 - Phase encode, mid-cell transition per bit
// RL3 - Start transition only before record's first
// RL4 - Load point is contiguous file characters
// RL5 - Stop in gap after load point
// RL6 - Record holds every supplied character
// RL7 - No character supplied ends record, write
// RL8 - Inter-record gap length by speed
// RL9 - Erase on during accel and decel
// RL10 - File bounded by file marks
// RL11 - File mark: speed erased length, characters
// RL12 - Interface sets mark character count
// RL13 - Fast search: two address characters
// RL14 - End mark: speed erased length, characters
// RL15 - Fast search end mark holds address
// RL16 - Track select; comm variant wide only
// RL17 - Refuse write to protected track
// RL18 - Parity: flat first cell, mid second
// RL19 - Read sync on unique parity bit
// RL20 - Bit sync regain on pair change
// RL21 - Odd parity over eight data bits
// RL22 - Gap lengths timed by speed config
module ctfw_writer
    import ctfw_pkg::*;
#(
    parameter int unsigned BIT_CYC_5  = BIT_CYC_5IPS,
    parameter int unsigned BIT_CYC_12 = BIT_CYC_12IPS
)(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Configuration and transport status
    input  wire ctfw_xport_t xport_i,
    input  wire logic        fast_search_option_i,
    input  wire logic [11:0] tape_addr_i,   // Four octal digits
    // Character stream from interface
    input  wire logic        chr_valid_i,
    input  wire logic [7:0]  chr_data_i,
    output logic             chr_ready_o,
    // Mark commands
    input  wire ctfw_mark_t  mark_cmd_i,
    input  wire logic        mark_last_i,   // Last mark character
    // Transport side
    output logic             motion_o,      // Tape driving
    output logic             erase_o,       // Erase head on
    output logic             write_o,       // Write current on
    output logic             flux_o,        // Write flux level
    output logic             track_wide_o,
    // Status
    output logic             busy_o,
    output logic             prot_err_o
);
    // Cell counts must give two halves and fit the 16-bit half-cell timer
    if (BIT_CYC_5 < 4 || BIT_CYC_12 < 4 ||
        BIT_CYC_5 > 32767 || BIT_CYC_12 > 32767) begin : g_bad_cell
        $error("bit cell count out of range");
    end

    // ==========================================================
    // State machine
    typedef enum logic [4:0] {
        CTFW_IDLE  = 5'b00001,
        CTFW_GAP   = 5'b00010,   // Erase while moving
        CTFW_CHR   = 5'b00100,   // Sending a character
        CTFW_NEXT  = 5'b01000,   // Take the next character or stop
        CTFW_STOP  = 5'b10000    // Decelerate with erase
    } ctfw_state_t;

    ctfw_state_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;       // Gap timer
    logic [8:0]  sh_q, sh_d;          // Data plus parity
    logic [3:0]  bit_q, bit_d;        // Bits sent in character
    logic        first_q, first_d;    // Next char is record's first
    ctfw_mark_t  mk_q, mk_d;
    logic        addr_q, addr_d;      // Second address char pending
    logic        prot_q, prot_d;
    logic        ready_q, ready_d;
    logic        start;
    logic        lead;
    logic        done;
    logic        flux;
    logic [15:0] half_cyc;
    logic [31:0] bitc;
    logic        wide_sel;
    logic        protected_w;
    logic [7:0]  load_byte;
    logic        have_chr;

    // Speed-dependent cell and gap lengths [RL22]
    assign bitc     = xport_i.fast_12ips ? BIT_CYC_12 : BIT_CYC_5;
    assign half_cyc = 16'(bitc >> 1);
    // Comm variant forces the wide track [RL16]
    assign wide_sel    = xport_i.wide_track | xport_i.comm_variant;
    assign protected_w = wide_sel ? xport_i.prot_wide : xport_i.prot_narrow;  // [RL17]

    // Gap length in cycles for the requested erase
    function automatic logic [31:0] gap_cyc(input ctfw_mark_t m, input logic f, input logic [31:0] b);
        logic [31:0] mil;
        mil = 32'(f ? IRG_MIL_12IPS : IRG_MIL_5IPS);                  // [RL8]
        case (m)
            CTFW_MK_LOAD, CTFW_MK_FILE: mil = 32'(f ? FMK_MIL_12IPS : FMK_MIL_5IPS); // [RL11]
            CTFW_MK_EOD:  mil = 32'(f ? EOD_MIL_12IPS : EOD_MIL_5IPS);             // [RL14]
            default:      mil = mil;
        endcase
        gap_cyc = mil * b;
    endfunction : gap_cyc

    // Fast search supplies the address characters itself [RL13] [RL15]
    assign have_chr  = (fast_search_option_i && mk_q != CTFW_MK_NONE) ? 1'b1 : chr_valid_i;
    assign load_byte = (fast_search_option_i && mk_q != CTFW_MK_NONE)
                     ? (addr_q ? {2'h0, tape_addr_i[5:0]} : {2'h0, tape_addr_i[11:6]})
                     : chr_data_i;

    // ==========================================================
    // Next state
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        bit_d   = bit_q;
        first_d = first_q;
        mk_d    = mk_q;
        addr_d  = addr_q;
        prot_d  = prot_q;
        ready_d = 1'b0;
        start   = 1'b0;
        lead    = 1'b0;
        case (st_q)
            CTFW_IDLE: begin
                if (mark_cmd_i != CTFW_MK_NONE || chr_valid_i) begin
                    if (protected_w) begin
                        prot_d = 1'b1;                                // [RL17]
                    end else begin
                        prot_d = 1'b0;
                        mk_d   = mark_cmd_i;
                        addr_d = 1'b0;
                        cnt_d  = gap_cyc(mark_cmd_i, xport_i.fast_12ips, bitc);
                        st_d   = CTFW_GAP;                            // [RL9] [RL10]
                    end
                end
            end
            CTFW_GAP: begin
                // Erase during acceleration and mark gap
                if (cnt_q > 32'h0000_0001) begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end else begin
                    first_d = 1'b1;
                    st_d    = CTFW_NEXT;
                end
            end
            CTFW_NEXT: begin
                if (have_chr) begin
                    // Odd parity in bit 8 [RL21]
                    sh_d    = {~(^load_byte), load_byte};
                    ready_d = ~(fast_search_option_i && mk_q != CTFW_MK_NONE);  // [RL6]
                    bit_d   = 4'h0;
                    start   = 1'b1;
                    lead    = first_q;                                // [RL3]
                    first_d = 1'b0;
                    st_d    = CTFW_CHR;
                end else begin
                    // Demand lapsed: close the record [RL7] [RL5]
                    cnt_d = gap_cyc(CTFW_MK_NONE, xport_i.fast_12ips, bitc);
                    st_d  = CTFW_STOP;
                end
            end
            CTFW_CHR: begin
                if (done) begin
                    if (bit_q == 4'(DATA_BITS)) begin
                        // Parity cell ended: next char back to back [RL1] [RL4]
                        if (mk_q != CTFW_MK_NONE && fast_search_option_i) begin
                            addr_d = 1'b1;
                            if (addr_q) begin
                                cnt_d = gap_cyc(CTFW_MK_NONE, xport_i.fast_12ips, bitc);
                                st_d  = CTFW_STOP;                    // [RL13]
                            end else begin
                                st_d = CTFW_NEXT;
                            end
                        end else if (mk_q != CTFW_MK_NONE && mark_last_i) begin
                            cnt_d = gap_cyc(CTFW_MK_NONE, xport_i.fast_12ips, bitc);
                            st_d  = CTFW_STOP;                        // [RL12]
                        end else begin
                            st_d = CTFW_NEXT;
                        end
                    end else begin
                        bit_d = bit_q + 4'h1;
                        sh_d  = {1'b0, sh_q[8:1]};
                        start = 1'b1;
                    end
                end
            end
            CTFW_STOP: begin
                // Erase while decelerating into the gap [RL9] [RL8]
                if (cnt_q > 32'h0000_0001) begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end else begin
                    mk_d = CTFW_MK_NONE;
                    st_d = CTFW_IDLE;
                end
            end
            default: st_d = CTFW_IDLE;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= CTFW_IDLE;
            cnt_q   <= 32'h0000_0000;
            sh_q    <= 9'h000;
            bit_q   <= 4'h0;
            first_q <= 1'b0;
            mk_q    <= CTFW_MK_NONE;
            addr_q  <= 1'b0;
            prot_q  <= 1'b0;
            ready_q <= 1'b0;
        end else if (ce_i) begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            bit_q   <= bit_d;
            first_q <= first_d;
            mk_q    <= mk_d;
            addr_q  <= addr_d;
            prot_q  <= prot_d;
            ready_q <= ready_d;
        end
    end

    // Output registers
    logic motion_q, erase_q, write_q, wide_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motion_q <= 1'b0;
            erase_q  <= 1'b0;
            write_q  <= 1'b0;
            wide_q   <= 1'b0;
        end else if (ce_i) begin
            motion_q <= (st_d != CTFW_IDLE);
            erase_q  <= (st_d == CTFW_GAP) || (st_d == CTFW_STOP);   // [RL9]
            // Write stays on between characters of one record [RL3]
            write_q  <= (st_d == CTFW_CHR) || (st_d == CTFW_NEXT && !first_d);
            wide_q   <= wide_sel;                                      // [RL16]
        end
    end

    // Cell encoder [RL2] [RL18]
    ctfw_bit_enc u_enc (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .half_cyc_i (half_cyc),
        .start_i    (start),
        .bit_i      (st_q == CTFW_CHR ? sh_q[1] : sh_d[0]),
        .par_i      (st_q == CTFW_CHR && bit_q == 4'(DATA_BITS - 1)),  // Unique cell [RL19]
        .lead_i     (lead),                                             // Bit sync edge [RL20]
        .flux_o     (flux),
        .done_o     (done)
    );

    assign motion_o     = motion_q;
    assign erase_o      = erase_q;
    assign write_o      = write_q;
    assign flux_o       = flux;
    assign track_wide_o = wide_q;
    assign busy_o       = motion_q;
    assign prot_err_o   = prot_q;
    assign chr_ready_o  = ready_q;
endmodule : ctfw_writer

/* rtl/ctfw_pkg.sv */
package ctfw_pkg;
    // ==========================================================
    // Timing, 50 MHz clock
    localparam int unsigned CLK_HZ          = 50_000_000;
    // Bit cell at 1000 bpi: 200 us at 5 ips, about 83 us at 12 ips
    localparam int unsigned BIT_NS_5IPS     = 200_000;
    localparam int unsigned BIT_NS_12IPS    = 83_333;
    localparam int unsigned BIT_CYC_5IPS    = BIT_NS_5IPS / 20;
    localparam int unsigned BIT_CYC_12IPS   = BIT_NS_12IPS / 20;
    // Erased lengths in mils of tape
    localparam int unsigned IRG_MIL_5IPS    = 100;
    localparam int unsigned IRG_MIL_12IPS   = 450;
    localparam int unsigned FMK_MIL_5IPS    = 800;
    localparam int unsigned FMK_MIL_12IPS   = 1450;
    localparam int unsigned EOD_MIL_5IPS    = 1600;
    localparam int unsigned EOD_MIL_12IPS   = 2900;
    // One bit cell is one mil of tape at 1000 bpi
    localparam int unsigned DATA_BITS       = 8;
    localparam int unsigned ADDR_CHARS      = 2;
    localparam logic [1:0]  RST_MARK        = 2'h0;

    // ==========================================================
    // Mark commands
    typedef enum logic [1:0] {
        CTFW_MK_NONE = 2'h0,
        CTFW_MK_LOAD = 2'h1,
        CTFW_MK_FILE = 2'h2,
        CTFW_MK_EOD  = 2'h3
    } ctfw_mark_t;

    // Transport status bundle
    typedef struct packed {
        logic fast_12ips;   // Transport speed is 12 ips
        logic wide_track;   // Wide track selected
        logic prot_narrow;  // Narrow track write-protected
        logic prot_wide;    // Wide track write-protected
        logic comm_variant; // Comm terminal variant: wide track only
    } ctfw_xport_t;
endpackage : ctfw_pkg

/* rtl/ctfw_bit_enc.sv */
`timescale 1ns/1ns
// Phase encoder for one bit cell; parity cell is double length
module ctfw_bit_enc
    import ctfw_pkg::*;
(
    // Clock and control
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] half_cyc_i,  // Half bit cell in cycles
    // Bit request
    input  wire logic        start_i,     // Start a cell
    input  wire logic        bit_i,       // Data value
    input  wire logic        par_i,       // Cell is the parity cell
    input  wire logic        lead_i,      // Emit a start transition first
    // Outputs
    output logic             flux_o,      // Write current polarity
    output logic             done_o       // Cell finished pulse
);
    logic [15:0] cnt_q, cnt_d;
    logic [2:0]  half_q, half_d;   // Remaining half-cells
    logic        flux_q, flux_d;
    logic        done_q, done_d;
    logic        par_q,  par_d;

    // ==========================================================
    // Next state
    always_comb begin
        cnt_d  = cnt_q;
        half_d = half_q;
        flux_d = flux_q;
        done_d = 1'b0;
        par_d  = par_q;
        if (start_i) begin
            // Lead-in half cell gives the record's start transition
            half_d = par_i ? 3'h4 : 3'h2;
            if (lead_i) begin
                half_d = half_d + 3'h1;
            end
            cnt_d = half_cyc_i;
            par_d = par_i;
            // First half level: bit 1 is low-then-high; parity sits at ~value while flat
            // A lead half starts at the bit value, so its closing edge is the start mark
            flux_d = lead_i ? bit_i : ~bit_i;
        end else if (half_q != 3'h0) begin
            if (cnt_q <= 16'h0001) begin
                cnt_d  = half_cyc_i;
                half_d = half_q - 3'h1;
                // Parity: no change in first cell, mid-cell change in second
                if (par_q ? (half_q == 3'h2) : (half_q == 3'h2 || half_q == 3'h3)) begin
                    flux_d = ~flux_q;
                end
                if (half_q == 3'h1) begin
                    done_d = 1'b1;
                end
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end

    // Register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= 16'h0000;
            half_q <= 3'h0;
            flux_q <= 1'b0;
            done_q <= 1'b0;
            par_q  <= 1'b0;
        end else if (ce_i) begin
            cnt_q  <= cnt_d;
            half_q <= half_d;
            flux_q <= flux_d;
            done_q <= done_d;
            par_q  <= par_d;
        end
    end

    assign flux_o = flux_q;
    assign done_o = done_q;
endmodule : ctfw_bit_enc

/* tb/ctfw_writer_properties.sv */
`timescale 1ns/1ns
// ====================================
// Port checker for the writer
module ctfw_writer_chk
    import ctfw_pkg::*;
#(
    parameter int unsigned BIT_CYC_5  = 8,
    parameter int unsigned BIT_CYC_12 = 8
)(
    // Clock and control
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire ctfw_xport_t xport_i,
    input wire logic        fast_search_option_i,
    input wire logic [11:0] tape_addr_i,
    // Characters and marks
    input wire logic        chr_valid_i,
    input wire logic [7:0]  chr_data_i,
    input wire logic        chr_ready_o,
    input wire ctfw_mark_t  mark_cmd_i,
    input wire logic        mark_last_i,
    // Transport and status
    input wire logic        motion_o,
    input wire logic        erase_o,
    input wire logic        write_o,
    input wire logic        flux_o,
    input wire logic        track_wide_o,
    input wire logic        busy_o,
    input wire logic        prot_err_o
);
    logic [15:0] gap_q, gap_d; // Erase cycles before writing
    logic [15:0] run_q, run_d; // Write cycles since flux change
    logic        flx_q;        // Flux one cycle back
    ctfw_mark_t  mk_q, mk_d;   // Mark kind of this operation
    wire logic        fast_w = xport_i.fast_12ips;
    wire logic [15:0] cell_w = fast_w ? 16'(BIT_CYC_12) : 16'(BIT_CYC_5);
    wire logic        wide_w = xport_i.wide_track | xport_i.comm_variant;
    wire logic        prot_w = wide_w ? xport_i.prot_wide : xport_i.prot_narrow;
    wire logic        go_w   = !busy_o && ce_i && (chr_valid_i || mark_cmd_i != CTFW_MK_NONE);
    // Load gap is left open, so it is not judged
    wire logic [15:0] mil_w  = 16'(
        (mk_q == CTFW_MK_EOD)  ? (fast_w ? EOD_MIL_12IPS : EOD_MIL_5IPS) :
        (mk_q == CTFW_MK_FILE) ? (fast_w ? FMK_MIL_12IPS : FMK_MIL_5IPS) :
                                 (fast_w ? IRG_MIL_12IPS : IRG_MIL_5IPS));
    wire logic [15:0] exp_w  = mil_w * cell_w;
    // Counters freeze with the enable, as the writer does
    always_comb begin
        mk_d  = rst_i ? CTFW_MK_NONE : go_w ? mark_cmd_i : mk_q;
        gap_d = (rst_i || !motion_o) ? 16'h0 : (ce_i && !write_o) ? gap_q + 16'h1 : gap_q;
        run_d = (rst_i || !write_o || flux_o != flx_q) ? 16'h0 : run_q + 16'(ce_i);
    end
    always_ff @(posedge clk_i) begin
        mk_q  <= mk_d;
        gap_q <= gap_d;
        run_q <= run_d;
        flx_q <= flux_o;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Small slack for registered start and stop
    property gap_ok_p;
        $rose(write_o) && mk_q != CTFW_MK_LOAD |-> gap_q + 16'h3 >= exp_w && gap_q <= exp_w + 16'h3;
    endproperty
    gap_len_a: assert property (gap_ok_p)
        else $error("erased gap length wrong");
    prot_flag_a: assert property (go_w && prot_w |-> ##[1:2] prot_err_o)
        else $error("protected start not flagged");
    prot_still_a: assert property (prot_err_o |-> !write_o && !erase_o)
        else $error("protected track touched");
    track_sel_a: assert property (write_o |-> track_wide_o == wide_w)
        else $error("wrong track");
    lead_erase_a: assert property ($rose(motion_o) |-> ##[0:1] erase_o && !write_o)
        else $error("no erase on start");
    stop_erase_a: assert property ($fell(write_o) |-> ##[0:1] erase_o)
        else $error("no erase on stop");
    ready_pulse_a: assert property (chr_ready_o |-> busy_o ##1 !chr_ready_o)
        else $error("ready not a pulse");
    flux_cell_a: assert property (write_o |-> run_q <= 16'h2 * cell_w + 16'h1)
        else $error("flux cell too long");
    rec_c: cover property ($rose(write_o));
    prot_c: cover property ($rose(prot_err_o));
    fast_c: cover property ($rose(busy_o) && fast_search_option_i);
endmodule : ctfw_writer_chk

bind ctfw_writer ctfw_writer_chk #(.BIT_CYC_5(BIT_CYC_5), .BIT_CYC_12(BIT_CYC_12)) u_chk (.*);

/* tb/ctfw_tape_model.sv */
`timescale 1ns/1ns
// ====================================
// Head read-back: recovers characters from flux
module ctfw_tape_model #(
    parameter int unsigned BIT_CYC = 8
)(
    // Head side
    input  wire logic  clk_i,
    input  wire logic  write_i,
    input  wire logic  flux_i,
    // Recovered character
    output logic       chr_seen_o,
    output logic [8:0] chr_o,    // Parity then data
    output logic [3:0] nbits_o   // Data cells before parity
);
    logic        prev_q; // Last flux level
    logic        wr_q;   // Write on one cycle back; write-on level step is no edge
    logic        sync_q; // Start transition seen
    logic [15:0] run_q;  // Cycles since last mid-cell edge
    logic [7:0]  sh_q;   // Data, LSB first
    logic [3:0]  n_q;    // Data cells so far
    always_ff @(posedge clk_i) begin
        chr_seen_o <= 1'b0;
        prev_q     <= flux_i;
        wr_q       <= write_i;
        run_q      <= run_q + 16'h1;
        if (!write_i) begin
            sync_q <= 1'b0;
            n_q    <= 4'h0;
        end else if (wr_q && flux_i != prev_q) begin
            if (!sync_q) begin // Start edge sits half a cell before the first mid
                sync_q <= 1'b1;
                run_q  <= 16'(BIT_CYC / 2 + 1);
            end else if (run_q < 16'(BIT_CYC * 7 / 8)) begin
                // Cell boundary edge, no data
            end else if (run_q < 16'(BIT_CYC * 3 / 2)) begin // Mid-cell edge
                sh_q  <= {flux_i, sh_q[7:1]};
                n_q   <= n_q + 4'h1;
                run_q <= 16'h1;
            end else begin // Flat cell first means parity
                chr_seen_o <= 1'b1;
                chr_o      <= {flux_i, sh_q};
                nbits_o    <= n_q;
                n_q        <= 4'h0;
                run_q      <= 16'h1;
            end
        end
    end
endmodule : ctfw_tape_model

/* tb/tb_cassette_tape_format_writer.sv */
`timescale 1ns/1ns
// ====================================
// Writer bench
module tb_cassette_tape_format_writer;
    import ctfw_pkg::*;
    localparam int unsigned BC = 8; // Short cell keeps gaps brief
    logic        clk_i, rst_i, ce_i, chr_valid_i, mark_last_i, fast_search_option_i;
    logic        chr_ready_o, motion_o, erase_o, write_o, flux_o, track_wide_o;
    logic        busy_o, prot_err_o, seen;
    ctfw_xport_t xport_i;
    ctfw_mark_t  mark_cmd_i;
    logic [11:0] tape_addr_i;
    logic [7:0]  chr_data_i;
    logic [8:0]  got_c;
    logic [3:0]  got_n;
    logic [12:0] exp_q[$]; // Cell count, parity, data
    int          fails, cmp_count, seed;

    ctfw_writer #(.BIT_CYC_5(BC), .BIT_CYC_12(BC)) DUT (.*);
    ctfw_tape_model #(.BIT_CYC(BC)) u_tape (.clk_i(clk_i), .write_i(write_o), .flux_i(flux_o),
        .chr_seen_o(seen), .chr_o(got_c), .nbits_o(got_n));

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [12:0] e, input logic [12:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // Odd parity note for one character
    function automatic logic [12:0] note(input logic [7:0] d);
        return {4'h8, ~^d, d};
    endfunction : note
    task automatic send(input logic [7:0] d, input logic last);
        int n;
        exp_q.push_back(note(d));
        chr_data_i = d;
        chr_valid_i = 1'b1;
        n = 0;
        do begin
            tick();
            n++;
        end while (chr_ready_o !== 1'b1 && n < 30000);
        check("ready", 13'h1, 13'(chr_ready_o));
        // Last-mark flag goes up only once this character is latched
        mark_last_i = last;
    endtask : send
    // Hold the command until the writer turns busy
    task automatic mark(input ctfw_mark_t m);
        int n;
        mark_cmd_i = m;
        n = 0;
        do begin
            tick();
            n++;
        end while (busy_o !== 1'b1 && n < 8);
        mark_cmd_i = CTFW_MK_NONE;
    endtask : mark
    task automatic finish_op;
        int n;
        chr_valid_i = 1'b0;
        n = 0;
        while (busy_o !== 1'b0 && n < 40000) begin
            tick();
            n++;
        end
        mark_last_i = 1'b0;
        check("busy", 13'h0, 13'(busy_o));
        check("motion", 13'h0, 13'(motion_o));
        check("pending", 13'h0, 13'(exp_q.size()));
    endtask : finish_op
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // Read-back monitor takes the oldest note
    always @(posedge clk_i) begin
        if (seen === 1'b1)
            check("char", exp_q.size() ? exp_q.pop_front() : 13'h0, {got_n, got_c});
    end
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #(80000 * 20);
        fails++;
        stop_test();
    end
    initial begin
        seed = 99263;
        {rst_i, ce_i, chr_valid_i, mark_last_i, fast_search_option_i} = 5'b11000;
        xport_i = '0;
        mark_cmd_i = CTFW_MK_NONE;
        tape_addr_i = 12'h000;
        chr_data_i = 8'h00;
        repeat (10) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        // One three-character record at each speed, stopping between them
        for (int s = 0; s < 2; s++) begin
            xport_i.fast_12ips = (s == 1);
            send(8'hFF, 1'b0);
            repeat (2) send(8'($random(seed)), 1'b0);
            finish_op();
        end
        $display("record test done");
        // Protected narrow track refuses a start
        xport_i = '0;
        xport_i.prot_narrow = 1'b1;
        chr_valid_i = 1'b1;
        repeat (3) tick();
        check("prot_err", 13'h1, 13'(prot_err_o));
        check("motion", 13'h0, 13'(motion_o));
        chr_valid_i = 1'b0;
        xport_i.prot_narrow = 1'b0;
        $display("protect test done");
        // Load point on the wide-only variant
        xport_i.comm_variant = 1'b1;
        mark(CTFW_MK_LOAD);
        send(8'($random(seed)), 1'b1);
        finish_op();
        // Address marks under fast search
        fast_search_option_i = 1'b1;
        for (int k = 0; k < 2; k++) begin
            tape_addr_i = 12'($random(seed));
            exp_q.push_back(note({2'h0, tape_addr_i[11:6]}));
            exp_q.push_back(note({2'h0, tape_addr_i[5:0]}));
            mark(k ? CTFW_MK_EOD : CTFW_MK_FILE);
            finish_op();
        end
        // Interface-sized file mark, enable dropped in the gap
        fast_search_option_i = 1'b0;
        xport_i.fast_12ips = 1'b1;
        mark(CTFW_MK_FILE);
        ce_i = 1'b0;
        repeat (5) tick();
        ce_i = 1'b1;
        for (int k = 0; k < 3; k++) send(8'($random(seed)), k == 2);
        finish_op();
        $display("mark test done");
        stop_test();
    end
endmodule : tb_cassette_tape_format_writer
